//--- rtl/nvm_map.svh
/*
  Register offsets, control field positions, reset values and timing counts
  of the nonvolatile byte store controller.
  Assumes a 125 MHz system clock and an 8-bit register port.
*/
`ifndef NVM_MAP_SVH
`define NVM_MAP_SVH

`define NVM_CTRL_OFS 8'h1F
`define NVM_BUF_OFS 8'h20
`define NVM_IDXL_OFS 8'h21
`define NVM_IDXH_OFS 8'h22

`define NVM_READ_BIT 0
`define NVM_STROBE_BIT 1
`define NVM_UNLOCK_BIT 2
`define NVM_RIE_BIT 3
`define NVM_MODE_LO 4
`define NVM_MODE_HI 5

`define NVM_IDX_W 6
`define NVM_TIMER_W 19
`define NVM_ERASED 8'hFF
`define NVM_ZERO8 8'h00

`define NVM_UNLOCK_CYCLES 3'h4
`define NVM_PROG_STALL 3'h2
`define NVM_READ_STALL 3'h4

`define NVM_MCLK_PERIOD_NS 8
`define NVM_ATOMIC_TIME_NS 3400000
`define NVM_SPLIT_TIME_NS 1800000
`define NVM_ATOMIC_CYCLES ((`NVM_ATOMIC_TIME_NS + `NVM_MCLK_PERIOD_NS - 1) / `NVM_MCLK_PERIOD_NS)
`define NVM_SPLIT_CYCLES ((`NVM_SPLIT_TIME_NS + `NVM_MCLK_PERIOD_NS - 1) / `NVM_MCLK_PERIOD_NS)

`endif

//--- rtl/nvm_pkg.sv
/*
  Types of the nonvolatile byte store controller: operation codes and
  engine states.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package nvm_pkg;

  typedef enum logic [1:0] {
    OP_ATOMIC = 2'b00,
    OP_ERASE = 2'b01,
    OP_WRITE = 2'b10,
    OP_RSVD = 2'b11
  } prog_op_t;

  typedef enum logic {
    ENG_IDLE = 1'b0,
    ENG_BUSY = 1'b1
  } eng_state_t;

endpackage

//--- rtl/eeprom_access_control.sv
/*
  Access controller for a 64-byte nonvolatile byte store: index, data and
  control registers, timed unlock, programming engine and core stall.
  Assumes a core that issues one-cycle register strobes on mclk and a
  power-on reset that stays high while the supply is sufficient.
*/
// Local design decision: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "nvm_map.svh"
// Overview of operation
// - Six-bit linear byte index, 0 to 63
// - Unused index and control top bits read zero
// - Buffer supplies write byte, receives read byte
// - Mode selects atomic, erase, write timings
// - Mode writes ignored while busy or when the strobe starts programming
// - Reset clears mode unless programming
// - Ready interrupt when enabled and idle
// - Unlock clears itself after four cycles
// - Strobe starts programming only when unlocked
// - Strobe stays set for programming time
// - Strobe start stalls core two cycles
// - No programming during flash self-write
// - Read fetches at once, stalls four cycles, or two if the same write starts programming
// - No read or index change while busy
// - Programming survives reset while supply holds
module eeprom_access_control #(
  parameter int unsigned ATOMIC_CYCLES = `NVM_ATOMIC_CYCLES,
  parameter int unsigned SPLIT_CYCLES = `NVM_SPLIT_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic power_on_rst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic core_irq_enable,
  input wire logic flash_selfwrite_active,
  output logic [7:0] rdata,
  output logic core_stall,
  output logic ready_irq
);

  function automatic logic [7:0] prog_result(input logic [7:0] old_byte,
                                             input logic [7:0] new_byte,
                                             input nvm_pkg::prog_op_t op);
    unique case (op)
      nvm_pkg::OP_ATOMIC: prog_result = new_byte;
      nvm_pkg::OP_ERASE: prog_result = `NVM_ERASED;
      nvm_pkg::OP_WRITE: prog_result = old_byte & new_byte;
      nvm_pkg::OP_RSVD: prog_result = old_byte;
    endcase
  endfunction

  // Byte store
  logic [7:0] mem [0:63];
  logic [7:0] next_mem_byte;

  // Register side
  logic [2:0] unlock_cnt;
  logic [2:0] next_unlock_cnt;
  logic irq_en;
  logic next_irq_en;
  logic read_flag;
  logic next_read_flag;
  logic [`NVM_IDX_W-1:0] index;
  logic [`NVM_IDX_W-1:0] next_index;
  logic [7:0] buffer;
  logic [7:0] next_buffer;
  logic [2:0] stall_cnt;
  logic [2:0] next_stall_cnt;
  logic next_core_stall;
  logic next_ready_irq;
  logic [7:0] next_rdata;

  // Engine side
  nvm_pkg::eng_state_t eng_state;
  nvm_pkg::eng_state_t next_eng_state;
  nvm_pkg::prog_op_t mode;
  nvm_pkg::prog_op_t next_mode;
  logic [`NVM_TIMER_W-1:0] timer;
  logic [`NVM_TIMER_W-1:0] next_timer;
  logic [`NVM_IDX_W-1:0] eng_tgt;
  logic [`NVM_IDX_W-1:0] next_eng_tgt;
  logic [7:0] eng_data;
  logic [7:0] next_eng_data;

  logic wr_ctrl;
  logic busy;
  logic unlock;
  logic start;
  logic read_go;
  logic commit;
  logic [7:0] read_byte;

  assign wr_ctrl = wr && (addr == `NVM_CTRL_OFS);
  assign busy = (eng_state == nvm_pkg::ENG_BUSY);
  assign unlock = (unlock_cnt != 3'h0);
  assign read_byte = mem[index];
  assign commit = busy && (timer == '0);
  assign start = wr_ctrl && wdata[`NVM_STROBE_BIT] && unlock && !busy
                 && !flash_selfwrite_active && (mode != nvm_pkg::OP_RSVD);
  assign read_go = wr_ctrl && wdata[`NVM_READ_BIT] && !busy;

  always_comb begin
    next_unlock_cnt = unlock_cnt;
    if (wr_ctrl && wdata[`NVM_UNLOCK_BIT]) begin
      next_unlock_cnt = `NVM_UNLOCK_CYCLES;
    end else if (unlock) begin
      next_unlock_cnt = unlock_cnt - 3'h1;
    end
    next_irq_en = wr_ctrl ? wdata[`NVM_RIE_BIT] : irq_en;
    next_read_flag = read_go;
    next_index = index;
    if (wr && (addr == `NVM_IDXL_OFS) && !busy) begin
      next_index = wdata[`NVM_IDX_W-1:0];
    end
    next_buffer = buffer;
    if (read_go) begin
      next_buffer = read_byte;
    end else if (wr && (addr == `NVM_BUF_OFS)) begin
      next_buffer = wdata;
    end
    next_stall_cnt = stall_cnt;
    if (start) begin
      next_stall_cnt = `NVM_PROG_STALL;
    end else if (read_go) begin
      next_stall_cnt = `NVM_READ_STALL;
    end else if (stall_cnt != 3'h0) begin
      next_stall_cnt = stall_cnt - 3'h1;
    end
    next_core_stall = (next_stall_cnt != 3'h0);
    next_ready_irq = irq_en && core_irq_enable && !busy;
    next_rdata = `NVM_ZERO8;
    if (rd) begin
      unique case (addr)
        `NVM_CTRL_OFS: next_rdata = {2'b00, mode, irq_en, unlock, busy, read_flag};
        `NVM_BUF_OFS: next_rdata = buffer;
        `NVM_IDXL_OFS: next_rdata = {2'b00, index};
        default: next_rdata = `NVM_ZERO8;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      unlock_cnt <= 3'h0;
      irq_en <= 1'b0;
      read_flag <= 1'b0;
      index <= '0;
      buffer <= `NVM_ZERO8;
      stall_cnt <= 3'h0;
      core_stall <= 1'b0;
      ready_irq <= 1'b0;
      rdata <= `NVM_ZERO8;
    end else begin
      unlock_cnt <= next_unlock_cnt;
      irq_en <= next_irq_en;
      read_flag <= next_read_flag;
      index <= next_index;
      buffer <= next_buffer;
      stall_cnt <= next_stall_cnt;
      core_stall <= next_core_stall;
      ready_irq <= next_ready_irq;
      rdata <= next_rdata;
    end
  end

  always_comb begin
    next_eng_state = eng_state;
    next_mode = mode;
    next_timer = timer;
    next_eng_tgt = eng_tgt;
    next_eng_data = eng_data;
    if (!rst_n && !busy) begin
      next_mode = nvm_pkg::OP_ATOMIC;
    end else if (wr_ctrl && !busy && !start) begin
      next_mode = nvm_pkg::prog_op_t'(wdata[`NVM_MODE_HI:`NVM_MODE_LO]);
    end
    unique case (eng_state)
      nvm_pkg::ENG_IDLE: begin
        if (start) begin
          next_eng_state = nvm_pkg::ENG_BUSY;
          next_timer = (mode == nvm_pkg::OP_ATOMIC)
                       ? `NVM_TIMER_W'(ATOMIC_CYCLES - 1)
                       : `NVM_TIMER_W'(SPLIT_CYCLES - 1);
          next_eng_tgt = index;
          next_eng_data = buffer;
        end
      end
      nvm_pkg::ENG_BUSY: begin
        if (commit) begin
          next_eng_state = nvm_pkg::ENG_IDLE;
        end else begin
          next_timer = timer - `NVM_TIMER_W'(1);
        end
      end
    endcase
  end

  // Engine runs on the power-on reset only, so a chip reset cannot cut it short
  always_ff @(posedge mclk or negedge power_on_rst_n) begin
    if (!power_on_rst_n) begin
      eng_state <= nvm_pkg::ENG_IDLE;
      mode <= nvm_pkg::OP_ATOMIC;
      timer <= '0;
      eng_tgt <= '0;
      eng_data <= `NVM_ZERO8;
    end else begin
      eng_state <= next_eng_state;
      mode <= next_mode;
      timer <= next_timer;
      eng_tgt <= next_eng_tgt;
      eng_data <= next_eng_data;
    end
  end

  always_comb begin
    next_mem_byte = prog_result(mem[eng_tgt], eng_data, mode);
  end

  always_ff @(posedge mclk) begin
    if (commit) begin
      mem[eng_tgt] <= next_mem_byte;
    end
  end

  // Helper: cycles spent busy
  logic [`NVM_TIMER_W:0] busy_len;
  logic [`NVM_TIMER_W:0] next_busy_len;
  always_comb begin
    next_busy_len = busy ? busy_len + 1'b1 : '0;
  end
  always_ff @(posedge mclk or negedge power_on_rst_n) begin
    if (!power_on_rst_n) begin
      busy_len <= '0;
    end else begin
      busy_len <= next_busy_len;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  logic unlock_set;
  assign unlock_set = wr_ctrl && wdata[`NVM_UNLOCK_BIT];

  a_unlock_timeout: assert property (unlock_set ##1 (!unlock_set)[*4] |=> !unlock)
    else $error("unlock did not expire after four cycles");
  a_strobe_locked: assert property (wr_ctrl && wdata[`NVM_STROBE_BIT] && !unlock && !busy
                                    |=> !busy)
    else $error("strobe started programming without unlock");
  a_flash_block: assert property (wr_ctrl && wdata[`NVM_STROBE_BIT] && flash_selfwrite_active
                                  && !busy |=> !busy)
    else $error("programming started during flash self-write");
  a_prog_length: assert property ($fell(busy) |-> busy_len == ((mode == nvm_pkg::OP_ATOMIC)
                                  ? ATOMIC_CYCLES : SPLIT_CYCLES))
    else $error("programming time wrong for mode");
  a_mode_locked: assert property (busy |=> mode == $past(mode))
    else $error("mode changed while programming");
  a_index_locked: assert property (busy |=> $stable(index))
    else $error("index changed while programming");
  a_read_blocked: assert property (wr_ctrl && wdata[`NVM_READ_BIT] && busy |=> !read_flag)
    else $error("read performed while programming");
  a_read_fetch: assert property (read_go |=> buffer == $past(read_byte))
    else $error("read byte not placed in buffer");
  a_read_stall: assert property (read_go |=> core_stall[*4])
    else $error("read stall shorter than four cycles");
  a_prog_stall: assert property (start ##1 (!start && !read_go)[*2] |-> core_stall
                                 ##1 !core_stall)
    else $error("program stall not two cycles");
  a_read_clear: assert property (read_flag && !read_go |=> !read_flag)
    else $error("read strobe bit did not clear");
  a_irq_idle: assert property (busy |=> !ready_irq)
    else $error("ready interrupt while busy");
  a_top_zero: assert property (rd && (addr == `NVM_CTRL_OFS || addr == `NVM_IDXL_OFS)
                               |=> rdata[7:6] == 2'b00)
    else $error("reserved bits read nonzero");
  a_mode_reset: assert property (@(posedge mclk) disable iff (!power_on_rst_n)
                                 !rst_n && !busy |=> mode == nvm_pkg::OP_ATOMIC)
    else $error("mode not cleared by reset");
  a_prog_survives: assert property (@(posedge mclk) disable iff (!power_on_rst_n)
                                    busy && !commit |=> busy)
    else $error("programming cut short");
  a_commit_data: assert property (commit && mode == nvm_pkg::OP_ATOMIC
                                  |=> mem[$past(eng_tgt)] == $past(eng_data))
    else $error("atomic program stored wrong byte");

  c_atomic_done: cover property ($fell(busy) && mode == nvm_pkg::OP_ATOMIC);
  c_erase_done: cover property ($fell(busy) && mode == nvm_pkg::OP_ERASE);
  c_read: cover property (read_go);
  c_unlock_lapse: cover property ($fell(unlock) && !busy);
  c_reset_busy: cover property (@(posedge mclk) disable iff (!power_on_rst_n) !rst_n && busy);

endmodule
`default_nettype wire

//--- verif/core_model.sv
/*
  Processor core model: issues one-cycle register writes and reads.
  Assumes the controller answers a read in the cycle after the strobe.
*/
`timescale 1ns/100ps
`default_nettype none
module core_model (
  input wire logic mclk,
  input wire logic [7:0] rdata,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd
);
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end

  // One register write: wr, addr and wdata driven for one cycle, then wr dropped
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a, output logic [7:0] q);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    q = rdata;
  endtask
endmodule
`default_nettype wire

//--- verif/eeprom_access_control_tb.sv
/*
  Self-checking bench of the byte store controller with a byte model.
  Assumes short programming counts set through the parameters.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module eeprom_access_control_tb;
  localparam int AT = 48;
  localparam int SP = 32;
  logic mclk = 1'b0;
  logic rst_n;
  logic por_n;
  logic cie;
  logic fsa;
  wire logic [7:0] addr;
  wire logic [7:0] wdata;
  wire logic [7:0] rdata;
  wire logic wr;
  wire logic rd;
  wire logic stall;
  wire logic irq;
  int fail_count = 0;
  int n_checks = 0;
  int mem[64];
  int idx;
  int d;
  logic [7:0] q;

  always #4 mclk = ~mclk;

  core_model core (.mclk(mclk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));

  eeprom_access_control #(.ATOMIC_CYCLES(AT), .SPLIT_CYCLES(SP)) DUT (
    .mclk(mclk), .rst_n(rst_n), .power_on_rst_n(por_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .core_irq_enable(cie), .flash_selfwrite_active(fsa),
    .rdata(rdata), .core_stall(stall), .ready_irq(irq));

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic expr(input logic [7:0] a, input logic [7:0] e, input string n);
    core.rreg(a, q);
    `CHK(n, e, q)
  endtask

  task automatic stalls(input int e);
    int c;
    c = 0;
    repeat (6) begin
      #1 c += int'(stall === 1'b1);
      @(posedge mclk);
    end
    `CHK("stall cycles", e, c)
  endtask

  task automatic rdmem(input int i);
    core.wreg(8'h21, 8'(i));
    core.wreg(8'h1F, 8'h09);
    stalls(4);
    expr(8'h1F, 8'h08, "read bit");
    expr(8'h20, 8'(mem[i]), "byte");
  endtask

  task automatic prog(input int m, input int i, input int v);
    core.wreg(8'h21, 8'(i));
    core.wreg(8'h20, 8'(v));
    core.wreg(8'h1F, 8'h08 | 8'(m << 4));
    core.wreg(8'h1F, 8'h0C | 8'(m << 4));
    core.wreg(8'h1F, 8'h0A | 8'(m << 4));
    stalls(2);
    core.wreg(8'h1F, 8'h39);
    stalls(0);
    core.wreg(8'h21, 8'(i ^ 1));
    expr(8'h1F, 8'h0A | 8'(m << 4), "busy ctrl");
    expr(8'h21, 8'(i), "busy index");
    `CHK("irq busy", 1'b0, irq)
    expr(8'h20, 8'(v), "busy buffer");
    repeat (m == 0 ? AT : SP) @(posedge mclk);
    expr(8'h1F, 8'h08 | 8'(m << 4), "done ctrl");
    `CHK("irq idle", 1'b1, irq)
    case (m)
      0: mem[i] = v;
      1: mem[i] = 255;
      default: mem[i] = mem[i] & v;
    endcase
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    final_report();
  end

  initial begin
    rst_n = 1'b0;
    por_n = 1'b0;
    cie = 1'b1;
    fsa = 1'b0;
    void'($urandom(32'hdfd2));
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    expr(8'h1F, 8'h00, "ctrl reset");
    core.wreg(8'h21, 8'hFF);
    core.wreg(8'h22, 8'hFF);
    expr(8'h21, 8'h3F, "index low");
    expr(8'h22, 8'h00, "index high");
    expr(8'h40, 8'h00, "unmapped");
    core.wreg(8'h1F, 8'h08);
    cie <= 1'b0;
    repeat (3) @(posedge mclk);
    `CHK("irq masked", 1'b0, irq)
    cie <= 1'b1;
    repeat (3) @(posedge mclk);
    `CHK("irq on", 1'b1, irq)
    $display("test reset and map done");
    idx = $urandom_range(63);
    for (int m = 0; m < 3; m++) begin
      d = $urandom_range(255, 1);
      prog(m, idx, d);
      rdmem(idx);
    end
    $display("test programming modes done");
    for (int k = 0; k < 4; k++) begin
      fsa <= (k == 3);
      core.wreg(8'h21, 8'(idx));
      core.wreg(8'h20, 8'h00);
      if (k != 1) core.wreg(8'h1F, k == 0 ? 8'h3C : 8'h0C);
      if (k == 2) repeat (6) @(posedge mclk);
      core.wreg(8'h1F, k == 0 ? 8'h3A : 8'h0A);
      repeat (4) @(posedge mclk);
      expr(8'h1F, k == 0 ? 8'h38 : 8'h08, "no start");
      fsa <= 1'b0;
      rdmem(idx);
    end
    $display("test refused starts done");
    core.wreg(8'h21, 8'(idx));
    core.wreg(8'h1F, 8'h14);
    core.wreg(8'h1F, 8'h1C);
    core.wreg(8'h1F, 8'h1A);
    repeat (3) @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    expr(8'h1F, 8'h12, "reset busy");
    repeat (SP) @(posedge mclk);
    mem[idx] = 255;
    rdmem(idx);
    core.wreg(8'h1F, 8'h28);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    expr(8'h1F, 8'h00, "reset idle");
    $display("test reset while busy done");
    final_report();
  end
endmodule
`default_nettype wire
